/* src/tcci_cfg.svh */
// Functional notes
// RULE_01 - Three 16-bit compare values checked every tick
// RULE_02 - Compare high byte staged, committed with low
// RULE_03 - Capture low read latches high byte
// RULE_04 - Capture event copies running count
// RULE_05 - Capture value may serve as TOP
// RULE_06 - Enable register layout, reserved bits zero
// RULE_07 - Request needs enable, global enable, flag
// RULE_08 - Flag layout; capture event sets capture flag
// RULE_09 - Capture-as-TOP: flag set at TOP
// RULE_10 - Match flag set one tick after equality
// RULE_11 - Forced match never sets match flag
// RULE_12 - Wrap flag set at mode-defined point
// RULE_13 - Vector taken clears matching flag
// RULE_14 - Writing one clears flag
// RULE_15 - Count write blocks matches next tick
// RULE_16 - Capture pin ignored while capture is TOP
// RULE_17 - Zero writes ignored; set beats clear
// RULE_18 - Compare reset zero; unused flag bits zero
`ifndef TCCI_CFG_SVH
`define TCCI_CFG_SVH
`define TCCI_AW 4
`define TCCI_ADR_CMPA_LO 4'h0
`define TCCI_ADR_CMPA_HI 4'h1
`define TCCI_ADR_CMPB_LO 4'h2
`define TCCI_ADR_CMPB_HI 4'h3
`define TCCI_ADR_CMPC_LO 4'h4
`define TCCI_ADR_CMPC_HI 4'h5
`define TCCI_ADR_CAP_LO 4'h6
`define TCCI_ADR_CAP_HI 4'h7
`define TCCI_ADR_IRQ_EN 4'h8
`define TCCI_ADR_IRQ_FLG 4'h9
`define TCCI_BIT_CAP 5
`define TCCI_BIT_MC 3
`define TCCI_BIT_MB 2
`define TCCI_BIT_MA 1
`define TCCI_BIT_WRAP 0
`define TCCI_IRQ_MASK 8'h2F
`define TCCI_CMP_RST 16'h0000
`define TCCI_CAP_RST 16'h0000
`define TCCI_MATCH_DLY 1
`endif

/* src/tcci_pkg.sv */
package tcci_pkg;
  // Waveform mode group as far as flags care
  typedef enum logic [1:0] {
    TCCI_MODE_NORMAL = 2'h0,
    TCCI_MODE_CLEAR_ON_MATCH = 2'h1,
    TCCI_MODE_OTHER = 2'h2
  } tcci_mode_t;
  typedef logic [7:0] tcci_byte_t;
  typedef logic [15:0] tcci_word_t;
endpackage : tcci_pkg

/* src/tcci_match.sv */
`timescale 1ns/1ps
`include "tcci_cfg.svh"
// One compare channel: value register and delayed match pulse
module tcci_match #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  input wire logic [WIDTH-1:0] count,
  input wire logic block,
  output logic [WIDTH-1:0] value_r,
  output logic hit_r
);
  initial
  begin
    if (WIDTH < 2 || WIDTH > 16)
      $error("tcci_match width unsupported");
  end

  // Value register; both bytes land together
  always_ff @(posedge clk)
  begin
    if (rst)
      value_r <= WIDTH'(`TCCI_CMP_RST);
    else if (ce && load)
      value_r <= load_value;
  end

  // Match registered one clock after the equal tick; forced matches never enter here
  always_ff @(posedge clk)
  begin
    if (rst)
      hit_r <= 1'b0;
    else if (ce)
      hit_r <= tick && !block && (count == value_r);
  end
endmodule : tcci_match

/* src/tcci_edge.sv */
`timescale 1ns/1ps
// Capture trigger edge detector with source and edge select
module tcci_edge (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic use_comparator,
  input wire logic rising_edge_sel,
  input wire logic pin_disconnect,
  output logic event_r
);
  logic prev_r;
  logic armed_r;
  logic src;

  assign src = use_comparator ? comparator_out : capture_input_pin;

  // Remember last sample of the chosen source
  always_ff @(posedge clk)
  begin
    if (rst)
      prev_r <= 1'b0;
    else if (ce)
      prev_r <= src;
  end

  // First sample after reset only primes prev_r; a source idling high gives no false edge
  always_ff @(posedge clk)
  begin
    if (rst)
      armed_r <= 1'b0;
    else if (ce)
      armed_r <= 1'b1;
  end

  // One pulse per selected edge; disconnected pin yields nothing
  always_ff @(posedge clk)
  begin
    if (rst)
      event_r <= 1'b0;
    else if (ce)
      event_r <= armed_r && !pin_disconnect && (rising_edge_sel ? (src && !prev_r) : (!src && prev_r));
  end
endmodule : tcci_edge

/* src/tcci_top.sv */
`timescale 1ns/1ps
`include "tcci_cfg.svh"
// Compare, capture and interrupt logic of a 16-bit timer
module tcci_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [`TCCI_AW-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata_r,
  input wire logic [15:0] running_count,
  input wire logic tick,
  input wire logic count_written,
  input wire logic wrap_event,
  input wire logic top_reached,
  input wire tcci_pkg::tcci_mode_t waveform_mode_select,
  input wire logic capture_is_top,
  input wire logic force_match_a,
  input wire logic force_match_b,
  input wire logic force_match_c,
  input wire logic capture_input_pin,
  input wire logic comparator_out,
  input wire logic use_comparator,
  input wire logic rising_edge_sel,
  input wire logic global_irq_en,
  input wire logic [5:0] vector_taken,
  output logic irq_r,
  output logic [2:0] match_out_r,
  output logic [15:0] capture_top_r
);
  import tcci_pkg::*;

  logic [7:0] temp_r;
  logic [7:0] irq_en_r;
  logic [7:0] flags_r;
  logic [15:0] capture_r;
  logic [15:0] cmp_value [3];
  logic [2:0] hit;
  logic [2:0] forces;
  logic cap_event;
  logic block_r;
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] flags_nxt;
  logic [7:0] rd_nxt;

  assign forces = {force_match_c, force_match_b, force_match_a};

  // RULE_15 block matches
  // Count write blanks compares on the following tick
  always_ff @(posedge clk)
  begin
    if (rst)
      block_r <= 1'b0;
    else if (ce && count_written)
      block_r <= 1'b1;
    else if (ce && tick)
      block_r <= 1'b0;
  end

  // RULE_02 shared high byte
  // Temp byte: loaded by high writes and by capture low reads
  always_ff @(posedge clk)
  begin
    if (rst)
      temp_r <= 8'h00;
    else if (ce && wr && (addr == `TCCI_ADR_CMPA_HI || addr == `TCCI_ADR_CMPB_HI ||
                          addr == `TCCI_ADR_CMPC_HI || addr == `TCCI_ADR_CAP_HI))
      temp_r <= wdata;
    // RULE_03 coherent capture read
    else if (ce && rd && addr == `TCCI_ADR_CAP_LO)
      temp_r <= capture_r[15:8];
  end

  // One channel per compare register
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_ch
      // RULE_01 compare channels
      // RULE_10 delayed match
      tcci_match #(.WIDTH(16)) u_match (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .tick(tick),
        .load(wr && addr == `TCCI_AW'(2 * g)),
        .load_value({temp_r, wdata}),
        .count(running_count),
        .block(block_r),
        .value_r(cmp_value[g]),
        .hit_r(hit[g])
      );
    end
  endgenerate

  // RULE_16 pin disconnected
  tcci_edge u_edge (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .capture_input_pin(capture_input_pin),
    .comparator_out(comparator_out),
    .use_comparator(use_comparator),
    .rising_edge_sel(rising_edge_sel),
    .pin_disconnect(capture_is_top),
    .event_r(cap_event)
  );

  // RULE_04 capture copy
  // Capture value; software may load it when used as TOP
  always_ff @(posedge clk)
  begin
    if (rst)
      capture_r <= `TCCI_CAP_RST;
    else if (ce && cap_event)
      capture_r <= running_count;
    else if (ce && wr && addr == `TCCI_ADR_CAP_LO)
      capture_r <= {temp_r, wdata};
  end

  // RULE_05 capture as TOP
  // Limit handed to the counter, registered for clean output
  always_ff @(posedge clk)
  begin
    if (rst)
      capture_top_r <= `TCCI_CAP_RST;
    else if (ce)
      capture_top_r <= capture_r;
  end

  // RULE_11 forced match output only
  // Match to waveform logic; forced strobes pass here, not into flags
  always_ff @(posedge clk)
  begin
    if (rst)
      match_out_r <= 3'h0;
    else if (ce)
      match_out_r <= hit | forces;
  end

  // RULE_06 enable layout
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_en_r <= 8'h00;
    else if (ce && wr && addr == `TCCI_ADR_IRQ_EN)
      irq_en_r <= wdata & `TCCI_IRQ_MASK;
  end

  // Flag set and clear terms
  always_comb
  begin
    flag_set = 8'h00;
    // RULE_08 capture flag
    // RULE_09 flag at TOP
    flag_set[`TCCI_BIT_CAP] = capture_is_top ? (ce && tick && top_reached) : cap_event;
    flag_set[`TCCI_BIT_MA] = hit[0];
    flag_set[`TCCI_BIT_MB] = hit[1];
    flag_set[`TCCI_BIT_MC] = hit[2];
    // RULE_12 wrap point
    if (waveform_mode_select == TCCI_MODE_OTHER)
      flag_set[`TCCI_BIT_WRAP] = tick && top_reached;
    else
      flag_set[`TCCI_BIT_WRAP] = tick && wrap_event;
    flag_clr = 8'h00;
    // RULE_14 write one clears
    if (wr && addr == `TCCI_ADR_IRQ_FLG)
      flag_clr = wdata;
    // RULE_13 vector clears
    flag_clr = flag_clr | {2'b00, vector_taken};
    // RULE_17 set wins
    flags_nxt = ((flags_r & ~flag_clr) | flag_set) & `TCCI_IRQ_MASK;
  end

  // RULE_18 unused bits zero
  always_ff @(posedge clk)
  begin
    if (rst)
      flags_r <= 8'h00;
    else if (ce)
      flags_r <= flags_nxt;
  end

  // RULE_07 three-way request
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_r <= 1'b0;
    else if (ce)
      irq_r <= global_irq_en && |(flags_nxt & irq_en_r);
  end

  // Read mux; high bytes of compares read directly, capture high via temp
  always_comb
  begin
    case (addr)
      `TCCI_ADR_CMPA_LO: rd_nxt = cmp_value[0][7:0];
      `TCCI_ADR_CMPA_HI: rd_nxt = cmp_value[0][15:8];
      `TCCI_ADR_CMPB_LO: rd_nxt = cmp_value[1][7:0];
      `TCCI_ADR_CMPB_HI: rd_nxt = cmp_value[1][15:8];
      `TCCI_ADR_CMPC_LO: rd_nxt = cmp_value[2][7:0];
      `TCCI_ADR_CMPC_HI: rd_nxt = cmp_value[2][15:8];
      `TCCI_ADR_CAP_LO: rd_nxt = capture_r[7:0];
      `TCCI_ADR_CAP_HI: rd_nxt = temp_r;
      `TCCI_ADR_IRQ_EN: rd_nxt = irq_en_r;
      `TCCI_ADR_IRQ_FLG: rd_nxt = flags_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else if (ce)
      rdata_r <= rd ? rd_nxt : 8'h00;
  end

  // Assertions
  chk_flag_sets_after_match: assert property (@(posedge clk) disable iff (rst) // RULE_10
    ce && hit[0] |=> flags_r[`TCCI_BIT_MA]) else $error("match A flag not set");
  chk_block_after_write: assert property (@(posedge clk) disable iff (rst) // RULE_15
    ce && tick && block_r |=> !hit[0] && !hit[1] && !hit[2])
    else $error("match not blocked after count write");
  chk_force_no_flag: assert property (@(posedge clk) disable iff (rst) // RULE_11
    ce && force_match_a && !hit[0] && !flags_r[`TCCI_BIT_MA] |=> !flags_r[`TCCI_BIT_MA])
    else $error("forced match set flag");
  chk_set_beats_clear: assert property (@(posedge clk) disable iff (rst) // RULE_17
    ce && flag_set[`TCCI_BIT_MB] |=> flags_r[`TCCI_BIT_MB]) else $error("set lost to clear");
  chk_w1c_clears: assert property (@(posedge clk) disable iff (rst) // RULE_14
    ce && wr && addr == `TCCI_ADR_IRQ_FLG && wdata[0] && !flag_set[0] |=> !flags_r[0])
    else $error("write one did not clear");
  chk_vector_clears: assert property (@(posedge clk) disable iff (rst) // RULE_13
    ce && vector_taken[`TCCI_BIT_MA] && !flag_set[`TCCI_BIT_MA] |=> !flags_r[`TCCI_BIT_MA])
    else $error("vector did not clear flag");
  chk_capture_copy: assert property (@(posedge clk) disable iff (rst) // RULE_04
    ce && cap_event |=> capture_r == $past(running_count)) else $error("capture missed count");
  chk_pin_disconnect: assert property (@(posedge clk) disable iff (rst) // RULE_16
    capture_is_top && $past(capture_is_top) |-> !cap_event) else $error("capture while TOP");
  chk_irq_three_way: assert property (@(posedge clk) disable iff (rst) // RULE_07
    ce && !global_irq_en |=> !irq_r) else $error("irq without global enable");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst) // RULE_18
    (flags_r & ~`TCCI_IRQ_MASK) == 8'h00 && (irq_en_r & ~`TCCI_IRQ_MASK) == 8'h00)
    else $error("reserved bit set");
  chk_capture_read_coherent: assert property (@(posedge clk) disable iff (rst) // RULE_03
    ce && rd && addr == `TCCI_ADR_CAP_LO |=> temp_r == $past(capture_r[15:8]))
    else $error("temp not latched on low read");

  // Clock enable low must hold every visible state
  chk_ce_freeze: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(irq_r) && $stable(flags_r) && $stable(rdata_r))
    else $error("state moved while ce low");

  // Read data return to zero outside the answer cycle
  chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    ce && !rd |=> rdata_r == 8'h00)
    else $error("read data without read");

  // High byte write parks in the shared temp byte
  chk_temp_high_write: assert property (@(posedge clk) disable iff (rst) // RULE_02
    ce && wr && addr == `TCCI_ADR_CMPA_HI |=> temp_r == $past(wdata))
    else $error("temp not loaded by high write");

  // Low write commits both bytes at once
  chk_low_commit: assert property (@(posedge clk) disable iff (rst) // RULE_02
    ce && wr && addr == `TCCI_ADR_CMPB_LO |=> cmp_value[1] == {$past(temp_r), $past(wdata)})
    else $error("compare B not committed as a word");

  // Compare high bytes read straight from the value
  chk_cmp_high_read: assert property (@(posedge clk) disable iff (rst) // RULE_01
    ce && rd && addr == `TCCI_ADR_CMPC_HI |=> rdata_r == $past(cmp_value[2][15:8]))
    else $error("compare C high byte read wrong");

  // Equality on a free tick raises the hit pulse
  chk_match_delay: assert property (@(posedge clk) disable iff (rst) // RULE_10
    ce && tick && !block_r && running_count == cmp_value[2] |=> hit[2])
    else $error("compare C match missed");

  // Forced strobes still reach the waveform side
  chk_force_output: assert property (@(posedge clk) disable iff (rst) // RULE_11
    ce && force_match_c |=> match_out_r[2])
    else $error("forced match C not passed on");

  // TOP reached with capture as TOP sets the capture flag
  chk_cap_top_flag: assert property (@(posedge clk) disable iff (rst) // RULE_09
    ce && capture_is_top && tick && top_reached |=> flags_r[`TCCI_BIT_CAP])
    else $error("capture flag missed at TOP");

  // Pin event sets the capture flag while the pin is connected
  chk_capture_flag_event: assert property (@(posedge clk) disable iff (rst) // RULE_08
    ce && cap_event && !capture_is_top |=> flags_r[`TCCI_BIT_CAP])
    else $error("capture flag missed on event");

  // Wrap flag in normal and clear-on-match modes
  chk_wrap_normal: assert property (@(posedge clk) disable iff (rst) // RULE_12
    ce && tick && wrap_event && waveform_mode_select != TCCI_MODE_OTHER |=> flags_r[`TCCI_BIT_WRAP])
    else $error("wrap flag missed on overflow");

  // Wrap flag at TOP in the other modes
  chk_wrap_other: assert property (@(posedge clk) disable iff (rst) // RULE_12
    ce && tick && top_reached && waveform_mode_select == TCCI_MODE_OTHER |=> flags_r[`TCCI_BIT_WRAP])
    else $error("wrap flag missed at TOP");

  // Enable writes keep reserved bits at zero
  chk_enable_write: assert property (@(posedge clk) disable iff (rst) // RULE_06
    ce && wr && addr == `TCCI_ADR_IRQ_EN |=> irq_en_r == ($past(wdata) & `TCCI_IRQ_MASK))
    else $error("enable write wrong");

  // All three conditions together must raise the request
  chk_irq_request: assert property (@(posedge clk) disable iff (rst) // RULE_07
    ce && global_irq_en && |(flags_nxt & irq_en_r) |=> irq_r)
    else $error("request missing");

  // TOP limit follows the capture value one cycle later
  chk_top_follow: assert property (@(posedge clk) disable iff (rst) // RULE_05
    ce |=> capture_top_r == $past(capture_r))
    else $error("TOP limit stale");

  // Zero write to the flags changes nothing
  chk_zero_write_keeps: assert property (@(posedge clk) disable iff (rst) // RULE_17
    ce && wr && addr == `TCCI_ADR_IRQ_FLG && wdata == 8'h00 && vector_taken == 6'h00
    |=> flags_r == (($past(flags_r) | $past(flag_set)) & `TCCI_IRQ_MASK))
    else $error("zero write changed flags");

  // Unmapped indexes read as zero
  chk_unused_read: assert property (@(posedge clk) disable iff (rst) // RULE_18
    ce && rd && addr > `TCCI_ADR_IRQ_FLG |=> rdata_r == 8'h00)
    else $error("unmapped read not zero");

  cov_match_irq: cover property (@(posedge clk) disable iff (rst) hit[0] ##1 irq_r);
  cov_capture: cover property (@(posedge clk) disable iff (rst) cap_event);
  cov_wrap: cover property (@(posedge clk) disable iff (rst) flag_set[`TCCI_BIT_WRAP]);
  cov_set_and_clear: cover property (@(posedge clk) disable iff (rst) flag_set[1] && flag_clr[1]);
  cov_cap_top: cover property (@(posedge clk) disable iff (rst) capture_is_top && tick && top_reached);
endmodule : tcci_top

/* testbench/tb_tcci_top.sv */
`timescale 1ns/1ps
`include "tcci_cfg.svh"
// Register-level bench for the compare, capture and interrupt block
module tb_tcci_top;
  import tcci_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata_r;
  logic [15:0] cnt = 16'h0FFF;
  logic tick = 1'b0;
  logic cw = 1'b0;
  logic wrap = 1'b0;
  logic topr = 1'b0;
  tcci_mode_t mode = TCCI_MODE_NORMAL;
  logic cap_top = 1'b0;
  logic [2:0] frc = 3'h0;
  logic pin = 1'b0;
  logic cmp = 1'b0;
  logic use_cmp = 1'b0;
  logic gie = 1'b0;
  logic [5:0] vec = 6'h00;
  logic irq_r;
  logic [2:0] match_out_r;
  logic [15:0] capture_top_r;
  logic [15:0] cv [3] = '{16'h1234, 16'h5678, 16'h9ABC};
  int err_total = 0;
  int compares = 0;

  tcci_top tcci_top_i (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .running_count(cnt), .tick(tick), .count_written(cw),
    .wrap_event(wrap), .top_reached(topr), .waveform_mode_select(mode),
    .capture_is_top(cap_top), .force_match_a(frc[0]), .force_match_b(frc[1]),
    .force_match_c(frc[2]), .capture_input_pin(pin), .comparator_out(cmp),
    .use_comparator(use_cmp), .rising_edge_sel(1'b1), .global_irq_en(gie),
    .vector_taken(vec), .irq_r(irq_r), .match_out_r(match_out_r), .capture_top_r(capture_top_r)
  );

  // Free-running 125 MHz clock
  initial
  begin
    forever #4 clk = ~clk;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic bad(input logic [15:0] e, input logic [15:0] g);
    err_total++;
    $display("BAD t=%0t exp=%h got=%h", $time, e, g);
  endtask : bad

  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
      bad({8'h00, e}, {8'h00, g});
  endtask : chk_byte

  task automatic chk_bit(input logic e, input logic g);
    #1;
    compares++;
    if (g !== e)
      bad({15'h0, e}, {15'h0, g});
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] e, input logic [15:0] g);
    #1;
    compares++;
    if (g !== e)
      bad(e, g);
  endtask : chk_word

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk_byte(e, rdata_r);
  endtask : rd_chk

  // One timer clock with a given count and counter events
  task automatic step(input logic [15:0] c, input logic w, input logic t);
    @(posedge clk);
    cnt <= c;
    tick <= 1'b1;
    wrap <= w;
    topr <= t;
    @(posedge clk);
    tick <= 1'b0;
    wrap <= 1'b0;
    topr <= 1'b0;
    idle(2);
  endtask : step

  // Rising edge on the chosen capture source, then back low
  task automatic cap_edge(input logic src);
    @(posedge clk);
    if (src)
      cmp <= 1'b1;
    else
      pin <= 1'b1;
    idle(4);
    cmp <= 1'b0;
    pin <= 1'b0;
    idle(4);
  endtask : cap_edge

  task automatic give_verdict;
    $display("err_total=%0d compares=%0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  // Cuts a hang short; the tests need a few hundred cycles
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end

  // Main test sequence
  initial
  begin
    idle(4);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++)
      rd_chk(i[3:0], 8'h00);
    rd_chk(4'hF, 8'h00);
    wr_reg(4'h8, 8'hFF);
    rd_chk(4'h8, 8'h2F);
    wr_reg(4'h8, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(4'(2 * i + 1), cv[i][15:8]);
      rd_chk(4'(2 * i + 1), 8'h00);
      wr_reg(4'(2 * i), cv[i][7:0]);
      rd_chk(4'(2 * i + 1), cv[i][15:8]);
      rd_chk(4'(2 * i), cv[i][7:0]);
    end
    step(16'h1234, 1'b0, 1'b0);
    rd_chk(4'h9, 8'h02);
    wr_reg(4'h9, 8'h2F);
    @(posedge clk);
    frc <= 3'h7;
    @(posedge clk);
    frc <= 3'h0;
    #1;
    chk_byte(8'h07, {5'h00, match_out_r});
    idle(3);
    rd_chk(4'h9, 8'h00);
    @(posedge clk);
    cw <= 1'b1;
    @(posedge clk);
    cw <= 1'b0;
    step(16'h5678, 1'b0, 1'b0);
    rd_chk(4'h9, 8'h00);
    step(16'h5678, 1'b0, 1'b0);
    step(16'h9ABC, 1'b0, 1'b0);
    rd_chk(4'h9, 8'h0C);
    for (int m = 0; m < 3; m++)
    begin
      wr_reg(4'h9, 8'h2F);
      mode <= tcci_mode_t'(m[1:0]);
      step(16'h0FFF, m < 2, m == 2);
      rd_chk(4'h9, 8'h01);
    end
    for (int s = 0; s < 2; s++)
    begin
      wr_reg(4'h9, 8'h2F);
      mode <= TCCI_MODE_NORMAL;
      use_cmp <= s[0];
      cnt <= 16'hABCD + 16'(s);
      cap_edge(s[0]);
      rd_chk(4'h9, 8'h20);
      rd_chk(4'h6, 8'hCD + 8'(s));
      cnt <= 16'h1111;
      cap_edge(s[0]);
      rd_chk(4'h7, 8'hAB);
    end
    wr_reg(4'h9, 8'h2F);
    cap_top <= 1'b1;
    cnt <= 16'h2222;
    cap_edge(1'b0);
    rd_chk(4'h9, 8'h00);
    wr_reg(4'h7, 8'h55);
    wr_reg(4'h6, 8'h66);
    idle(2);
    chk_word(16'h5566, capture_top_r);
    mode <= TCCI_MODE_OTHER;
    step(16'h5566, 1'b0, 1'b1);
    rd_chk(4'h9, 8'h21);
    cap_top <= 1'b0;
    mode <= TCCI_MODE_NORMAL;
    wr_reg(4'h9, 8'h2F);
    step(16'h1234, 1'b0, 1'b0);
    wr_reg(4'h8, 8'h0D);
    gie <= 1'b1;
    idle(2);
    chk_bit(1'b0, irq_r);
    wr_reg(4'h8, 8'h02);
    idle(2);
    chk_bit(1'b1, irq_r);
    gie <= 1'b0;
    idle(2);
    chk_bit(1'b0, irq_r);
    gie <= 1'b1;
    wr_reg(4'h9, 8'h00);
    rd_chk(4'h9, 8'h02);
    vec <= 6'h02;
    @(posedge clk);
    vec <= 6'h00;
    idle(2);
    rd_chk(4'h9, 8'h00);
    chk_bit(1'b0, irq_r);
    step(16'h1234, 1'b0, 1'b0);
    wr_reg(4'h9, 8'h02);
    rd_chk(4'h9, 8'h00);
    ce <= 1'b0;
    wr_reg(4'h8, 8'h2F);
    ce <= 1'b1;
    rd_chk(4'h8, 8'h02);
    give_verdict();
  end
endmodule : tb_tcci_top
